// >>> qprc_pkg.sv
`default_nettype none
package qprc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILTER_SLOW_NS = 20000;
    localparam int FILTER_FAST_NS = 2000;
    localparam int FILTER_SLOW_CYC =
        (FILTER_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_FAST_CYC =
        (FILTER_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_UNIT_NS = 1000000;
    localparam int PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [15:0] COUNT_LIMIT_MIN = 16'h000A;
    localparam logic [15:0] COUNT_LIMIT_MAX = 16'hFDE7;
    localparam logic [15:0] COUNT_LIMIT_DEFAULT = 16'h00FF;
    localparam logic [15:0] ON_POINT_DEFAULT = 16'h00FF;
    localparam logic [15:0] OFF_POINT_DEFAULT = 16'h0000;
    localparam logic [15:0] ERR_CODE_LIMIT = 16'h0001;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    localparam int NUM_CMP = 32;
    localparam int NUM_TIMED = 8;
    localparam int NUM_STROBE = 4;
    localparam int NUM_WORDS = 15;
    localparam int NUM_CMD_WORDS = 6;
    localparam int NUM_INPUTS = 8;

    // Status bit offsets from the image base
    localparam int SB_CMP = 0;
    localparam int SB_INPUT = 16;
    localparam int SB_STROBE = 20;
    localparam int SB_HOME_FOUND = 24;
    localparam int SB_PRELOAD_LATCH = 25;
    localparam int SB_HOME_SW = 26;
    localparam int SB_IN6 = 27;
    localparam int SB_READY = 30;
    localparam int SB_ERROR = 31;

    // Input vector positions: inputs 5 to 12
    localparam int IN_HOME_SW = 0;
    localparam int IN_GP = 1;
    localparam int IN_STROBE = 4;

    // Command bit positions
    localparam int CB_STROBE_RST = 0;
    localparam int CB_PRELOAD_RST = 4;
    localparam int CB_PRELOAD = 5;
    localparam int CB_HOME = 6;
    localparam int CB_ERR_CLR = 7;

    // Status word positions
    localparam int SW_STATUS_CODE = 0;
    localparam int SW_COUNT = 3;
    localparam int SW_STROBE = 6;
    localparam int SW_CMP_HI = 12;

    typedef enum logic [1:0] {
        HOME_IDLE = 2'b00,
        HOME_SEEK = 2'b01,
        HOME_FOUND = 2'b11
    } qprc_home_t;

    typedef struct packed {
        logic filter_fast;
        logic quadrature_count_function;
        logic [15:0] count_limit;
        logic [15:0] preload_value;
        logic [15:0] home_value;
        logic [7:0] pulse_mode;
    } qprc_cfg_t;

    typedef struct packed {
        logic [31:0][15:0] on_point;
        logic [31:0][15:0] off_point;
        logic [7:0][15:0] on_pulse_length;
        logic [7:0][15:0] off_pulse_length;
    } qprc_cmp_cfg_t;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic marker;
        logic preload;
    } qprc_enc_t;
endpackage
`default_nettype wire

// >>> qprc_filter.sv
`timescale 1ns/1ns
`default_nettype none
module qprc_filter #(
    parameter int WIDTH = 4,
    parameter int SLOW_CYC = qprc_pkg::FILTER_SLOW_CYC,
    parameter int FAST_CYC = qprc_pkg::FILTER_FAST_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic fast_sel,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] filt_out
);
    localparam int CW = $clog2(SLOW_CYC + 1);
    localparam logic [CW-1:0] SLOW_END = CW'(SLOW_CYC - 1);
    localparam logic [CW-1:0] FAST_END = CW'(FAST_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    logic [WIDTH-1:0] sync1_q, sync2_q, filt_q, filt_d;
    logic [WIDTH-1:0][CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] end_cnt;

    // A level passes only after holding steady for the whole window
    always_comb begin
        end_cnt = fast_sel ? FAST_END : SLOW_END;
        filt_d = filt_q;
        cnt_d = cnt_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (sync2_q[i] == filt_q[i]) begin
                cnt_d[i] = CNT_ZERO;
            end else if (cnt_q[i] >= end_cnt) begin
                filt_d[i] = sync2_q[i];
                cnt_d[i] = CNT_ZERO;
            end else begin
                cnt_d[i] = cnt_q[i] + CNT_ONE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            filt_q <= '0;
            cnt_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            filt_q <= filt_d;
            cnt_q <= cnt_d;
        end
    end

    assign filt_out = filt_q;
endmodule // qprc_filter
`default_nettype wire

// >>> qprc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - One filter, 20 us default or 2 us, on phases, marker, preload.
// - Counter runs zero to limit then wraps; limit 10..64999, default 255.
// - Panel or command preload loads the preload value into the counter.
// - During homing, a marker loads the home value into the counter.
// - Level mode holds output steady between turn-on and turn-off points.
// - Timed mode emits fixed pulses at both points instead of a level.
// - Output turns on when the count reaches its turn-on point.
// - Output turns off when the count reaches its turn-off point.
// - Timed mode: on-point pulse lasts first length in ms; zero means none.
// - Timed mode: off-point pulse lasts second length in ms; zero none.
// - Comparators 9 to 32 are level only; timing applies to 1 to 8.
// - Every scan the device offers 32 status bits and 15 status words.
// - Status bits are offsets from the image base; bit 0 comes first.
// - Status bits 0 to 15 show comparators 1 to 16 in order.
// - Bits 16-19 show inputs 9-12; bits 20-23 their strobe latches.
// - Bits 24-29: home found, preload latch, home switch, inputs 6-8.
// - A set strobe latch blocks further captures until host resets it.
// - Panel preload sets a latch that blocks panel preloads until cleared.
// - Homing with switch closed: first marker loads home, sets home found.
// - Bit 30 says module ready; bit 31 says an error was detected.
module qprc_top #(
    parameter int PULSE_CYC = qprc_pkg::PULSE_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire qprc_pkg::qprc_cfg_t cfg,
    input wire qprc_pkg::qprc_cmp_cfg_t cmp_cfg,
    input wire qprc_pkg::qprc_enc_t enc_pins,
    input wire logic [7:0] in_pins,
    input wire logic [31:0] command_bits,
    input wire logic [5:0][15:0] command_word_image,
    output logic [31:0] status_bit_image,
    output logic [14:0][15:0] status_word_image,
    output logic [31:0] comp_out
);
    localparam int MW = $clog2(PULSE_CYC + 1);
    localparam logic [MW-1:0] MS_END = MW'(PULSE_CYC - 1);
    localparam logic [MW-1:0] MS_ONE = MW'(1);
    localparam logic [MW-1:0] MS_ZERO = '0;
    localparam logic [15:0] ONE16 = 16'h0001;

    qprc_pkg::qprc_enc_t enc_f;
    logic [7:0] in_s1_q, in_s_q;
    logic a_prev_q, b_prev_q, mk_prev_q, pre_prev_q;
    logic [7:0] in_prev_q;
    logic [31:0] cmd_prev_q;
    logic [15:0] count_q, count_d;
    qprc_pkg::qprc_home_t home_q, home_d;
    logic pl_latch_q, pl_latch_d;
    logic [3:0] stb_latch_q, stb_latch_d;
    logic [3:0][15:0] stb_word_q, stb_word_d;
    logic [31:0] cmp_q, cmp_d;
    logic [7:0][15:0] tmr_q, tmr_d;
    logic [MW-1:0] ms_q, ms_d;
    logic err_q, err_d, ready_q;
    logic [31:0] sbi_q, sbi_d;
    logic [14:0][15:0] swi_q, swi_d;
    logic quad, step, up, limit_ok, panel_pre, cmd_pre, home_load;
    logic ms_tick, count_chg;
    logic [15:0] limit;
    logic [31:0] cmd_rise;
    logic [31:0] on_hit, off_hit;
    logic [3:0] stb_edge;

    qprc_filter #(
        .WIDTH(4)
    ) u_filter (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .fast_sel(cfg.filter_fast),
        .pin_in(enc_pins),
        .filt_out(enc_f)
    );

    always_comb begin
        quad = cfg.quadrature_count_function;
        limit_ok = cfg.count_limit >= qprc_pkg::COUNT_LIMIT_MIN &&
                   cfg.count_limit <= qprc_pkg::COUNT_LIMIT_MAX;
        // Bad limit falls back to the default rather than stalling
        limit = limit_ok ? cfg.count_limit
                         : qprc_pkg::COUNT_LIMIT_DEFAULT;
        // Host commands act on their rising edge only
        cmd_rise = command_bits & ~cmd_prev_q;
        step = quad && (enc_f.phase_a != a_prev_q ||
                        enc_f.phase_b != b_prev_q);
        up = enc_f.phase_a ^ b_prev_q;
        panel_pre = quad && enc_f.preload && !pre_prev_q &&
                    !pl_latch_q;
        cmd_pre = quad && cmd_rise[qprc_pkg::CB_PRELOAD];
        home_load = home_q == qprc_pkg::HOME_SEEK &&
                    in_s_q[qprc_pkg::IN_HOME_SW] &&
                    enc_f.marker && !mk_prev_q &&
                    !(panel_pre || cmd_pre);
        ms_tick = ms_q == MS_END;
        ms_d = ms_tick ? MS_ZERO : ms_q + MS_ONE;

        count_d = count_q;
        if (panel_pre || cmd_pre) begin
            count_d = cfg.preload_value;
        end else if (home_load) begin
            count_d = cfg.home_value;
        end else if (step && up) begin
            count_d = (count_q >= limit) ? 16'h0000
                                         : count_q + ONE16;
        end else if (step) begin
            count_d = (count_q == 16'h0000 || count_q > limit) ? limit
                                                               : count_q - ONE16;
        end

        home_d = home_q;
        if (cmd_rise[qprc_pkg::CB_HOME]) begin
            home_d = qprc_pkg::HOME_SEEK;
        end else if (home_load) begin
            home_d = qprc_pkg::HOME_FOUND;
        end

        // Set wins over a clear in the same cycle
        pl_latch_d = panel_pre || (pl_latch_q &&
                     !cmd_rise[qprc_pkg::CB_PRELOAD_RST]);
        stb_edge = in_s_q[7:4] & ~in_prev_q[7:4];
        stb_word_d = stb_word_q;
        for (int s = 0; s < qprc_pkg::NUM_STROBE; s++) begin
            if (stb_edge[s] && !stb_latch_q[s]) begin
                stb_word_d[s] = count_q;
            end
            stb_latch_d[s] = (stb_edge[s] && !stb_latch_q[s]) ||
                (stb_latch_q[s] &&
                 !cmd_rise[qprc_pkg::CB_STROBE_RST + s]);
        end

        // Equality on each change catches wraps as well as plain steps
        count_chg = count_d != count_q;
        cmp_d = cmp_q;
        tmr_d = tmr_q;
        for (int i = 0; i < qprc_pkg::NUM_CMP; i++) begin
            on_hit[i] = count_chg &&
                        count_d == cmp_cfg.on_point[i];
            off_hit[i] = count_chg &&
                         count_d == cmp_cfg.off_point[i];
            if (i < qprc_pkg::NUM_TIMED && cfg.pulse_mode[i]) begin
                if (on_hit[i]) begin
                    tmr_d[i] = cmp_cfg.on_pulse_length[i];
                end else if (off_hit[i]) begin
                    tmr_d[i] = cmp_cfg.off_pulse_length[i];
                end else if (ms_tick && tmr_q[i] != 16'h0000) begin
                    tmr_d[i] = tmr_q[i] - ONE16;
                end
                cmp_d[i] = tmr_d[i] != 16'h0000;
            end else begin
                // Upper comparators never see the mode bits
                if (i < qprc_pkg::NUM_TIMED) begin
                    tmr_d[i] = 16'h0000;
                end
                if (on_hit[i]) begin
                    cmp_d[i] = 1'b1;
                end else if (off_hit[i]) begin
                    cmp_d[i] = 1'b0;
                end
            end
        end

        err_d = !limit_ok || (err_q &&
                !cmd_rise[qprc_pkg::CB_ERR_CLR]);

        sbi_d = 32'h0000_0000;
        sbi_d[qprc_pkg::SB_CMP +: 16] = cmp_q[15:0];
        sbi_d[qprc_pkg::SB_INPUT +: 4] = in_s_q[7:4];
        sbi_d[qprc_pkg::SB_STROBE +: 4] = stb_latch_q;
        sbi_d[qprc_pkg::SB_HOME_FOUND] =
            quad && home_q == qprc_pkg::HOME_FOUND;
        sbi_d[qprc_pkg::SB_PRELOAD_LATCH] = quad && pl_latch_q;
        sbi_d[qprc_pkg::SB_HOME_SW] =
            quad && in_s_q[qprc_pkg::IN_HOME_SW];
        sbi_d[qprc_pkg::SB_IN6 +: 3] =
            quad ? in_s_q[qprc_pkg::IN_GP +: 3] : 3'h0;
        sbi_d[qprc_pkg::SB_READY] = ready_q;
        sbi_d[qprc_pkg::SB_ERROR] = err_q;

        swi_d = '0;
        swi_d[qprc_pkg::SW_STATUS_CODE] =
            err_q ? qprc_pkg::ERR_CODE_LIMIT : qprc_pkg::WORD_ZERO;
        swi_d[qprc_pkg::SW_COUNT] = count_q;
        for (int s = 0; s < qprc_pkg::NUM_STROBE; s++) begin
            swi_d[qprc_pkg::SW_STROBE + s] = stb_word_q[s];
        end
        swi_d[qprc_pkg::SW_CMP_HI] = cmp_q[31:16];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_s1_q <= '0;
            in_s_q <= '0;
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
            mk_prev_q <= 1'b0;
            pre_prev_q <= 1'b0;
            in_prev_q <= '0;
            cmd_prev_q <= '0;
            count_q <= 16'h0000;
            home_q <= qprc_pkg::HOME_IDLE;
            pl_latch_q <= 1'b0;
            stb_latch_q <= '0;
            stb_word_q <= '0;
            cmp_q <= '0;
            tmr_q <= '0;
            ms_q <= MS_ZERO;
            err_q <= 1'b0;
            ready_q <= 1'b0;
            sbi_q <= '0;
            swi_q <= '0;
        end else begin
            in_s1_q <= in_pins;
            in_s_q <= in_s1_q;
            a_prev_q <= enc_f.phase_a;
            b_prev_q <= enc_f.phase_b;
            mk_prev_q <= enc_f.marker;
            pre_prev_q <= enc_f.preload;
            in_prev_q <= in_s_q;
            cmd_prev_q <= command_bits;
            count_q <= count_d;
            home_q <= home_d;
            pl_latch_q <= pl_latch_d;
            stb_latch_q <= stb_latch_d;
            stb_word_q <= stb_word_d;
            cmp_q <= cmp_d;
            tmr_q <= tmr_d;
            ms_q <= ms_d;
            err_q <= err_d;
            ready_q <= 1'b1;
            sbi_q <= sbi_d;
            swi_q <= swi_d;
        end
    end

    assign status_bit_image = sbi_q;
    assign status_word_image = swi_q;
    assign comp_out = cmp_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence up_at_limit_s;
        step && up && count_q == limit && !panel_pre && !cmd_pre &&
        !home_load;
    endsequence

    sequence home_marker_s;
        home_load;
    endsequence

    wrap_to_zero_a: assert property (
        up_at_limit_s |=> count_q == 16'h0000)
        else $error("count did not wrap to zero");
    cmd_preload_a: assert property (
        cmd_pre |=> count_q == $past(cfg.preload_value))
        else $error("command preload not loaded");
    home_load_a: assert property (
        home_marker_s |=> count_q == $past(cfg.home_value) &&
        home_q == qprc_pkg::HOME_FOUND
        ##2 status_bit_image[qprc_pkg::SB_HOME_FOUND] == quad)
        else $error("home load or found flag wrong");
    panel_lock_a: assert property (
        pl_latch_q && enc_f.preload && !pre_prev_q && !cmd_pre &&
        !home_load && !step |=> $stable(count_q))
        else $error("latched panel preload acted");
    strobe_lock_a: assert property (
        stb_latch_q[0] && stb_edge[0] |=> $stable(stb_word_q[0]))
        else $error("locked strobe captured");
    level_on_a: assert property (on_hit[8] |=> cmp_q[8])
        else $error("level comparator did not turn on");
    level_off_a: assert property (
        off_hit[9] && !on_hit[9] |=> !cmp_q[9])
        else $error("level comparator did not turn off");
    pulse_start_a: assert property (
        cfg.pulse_mode[0] && on_hit[0] |=>
        tmr_q[0] == $past(cmp_cfg.on_pulse_length[0]) &&
        cmp_q[0] == (tmr_q[0] != 16'h0000))
        else $error("on pulse length not loaded");
    pulse_zero_a: assert property (
        cfg.pulse_mode[1] &&
        ((on_hit[1] && cmp_cfg.on_pulse_length[1] == 16'h0000) ||
         (off_hit[1] && !on_hit[1] &&
          cmp_cfg.off_pulse_length[1] == 16'h0000)) |=> !cmp_q[1])
        else $error("zero length pulse emitted");
    cmp_image_a: assert property (
        ##1 status_bit_image[15:0] == $past(cmp_q[15:0]))
        else $error("comparator status bits mismatch");
    count_word_a: assert property (
        ##1 status_word_image[qprc_pkg::SW_COUNT] == $past(count_q))
        else $error("count status word mismatch");
endmodule // qprc_top
`default_nettype wire

// >>> qprc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module qprc_host_model (
    input wire logic sys_clk,
    output logic [31:0] command_bits,
    output logic [5:0][15:0] command_word_image
);
    // Word commands carry nothing yet; held at zero every scan
    initial begin
        command_bits = 32'h00000000;
        command_word_image = {6{16'h0000}};
    end

    // Rise for one cycle then low, so a repeat of the same bit is seen
    task automatic cmd(input int b);
        command_bits[b] = 1'b1;
        @(posedge sys_clk);
        #1;
        command_bits[b] = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
endmodule // qprc_host_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [15:0] pv;
        logic [2:0] cmp;
    } qprc_row_t;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    qprc_pkg::qprc_cfg_t cfg;
    qprc_pkg::qprc_cmp_cfg_t cmp_cfg;
    qprc_pkg::qprc_enc_t enc_pins;
    logic [7:0] in_pins;
    logic [31:0] command_bits;
    logic [5:0][15:0] command_word_image;
    logic [31:0] status_bit_image;
    logic [14:0][15:0] status_word_image;
    logic [31:0] comp_out;
    int err_count = 0;
    int comparisons = 0;
    // Columns: preload value, then {comp 9, comp 2, comp 1}
    qprc_row_t rows [5] = '{'{16'h0005, 3'h5}, '{16'h0007, 3'h4},
        '{16'h000A, 3'h2}, '{16'h000C, 3'h0}, '{16'h0005, 3'h5}};

    always #5 sys_clk = ~sys_clk;

    // Pulse unit cut to 10 clocks so millisecond timers stay short
    qprc_top #(.PULSE_CYC(10)) dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cfg(cfg),
        .cmp_cfg(cmp_cfg),
        .enc_pins(enc_pins),
        .in_pins(in_pins),
        .command_bits(command_bits),
        .command_word_image(command_word_image),
        .status_bit_image(status_bit_image),
        .status_word_image(status_word_image),
        .comp_out(comp_out)
    );

    qprc_host_model host (
        .sys_clk(sys_clk),
        .command_bits(command_bits),
        .command_word_image(command_word_image)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_cnt(input logic [15:0] v);
        chk("count", {16'h0000, status_word_image[3]}, {16'h0000, v});
    endtask

    // Hold each phase state well past sync plus the 2 us window
    task automatic step(input logic up, input int n);
        logic a;
        repeat (n) begin
            a = enc_pins.phase_a;
            enc_pins.phase_a = up ? ~enc_pins.phase_b : enc_pins.phase_b;
            enc_pins.phase_b = up ? a : ~a;
            tick(250);
        end
    endtask

    // Index 0 is the panel preload pin, 1 the marker
    task automatic pulse_pin(input int idx);
        enc_pins[idx] = 1'b1;
        tick(250);
        enc_pins[idx] = 1'b0;
        tick(250);
    endtask

    task automatic strobe_edge;
        in_pins[4] = 1'b0;
        tick(10);
        in_pins[4] = 1'b1;
        tick(10);
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        test_done();
    end

    initial begin
        cfg = '{filter_fast: 1'b1, quadrature_count_function: 1'b1,
            count_limit: 16'h0014, preload_value: 16'h0000,
            home_value: 16'h000F, pulse_mode: 8'h03};
        for (int i = 0; i < 32; i++) begin
            cmp_cfg.on_point[i] = qprc_pkg::ON_POINT_DEFAULT;
            cmp_cfg.off_point[i] = qprc_pkg::OFF_POINT_DEFAULT;
        end
        cmp_cfg.on_pulse_length = {8{16'h0000}};
        cmp_cfg.off_pulse_length = {8{16'h0000}};
        cmp_cfg.on_point[0] = 16'h0005;
        cmp_cfg.off_point[0] = 16'h000A;
        cmp_cfg.on_pulse_length[0] = 16'h0003;
        cmp_cfg.on_point[1] = 16'h0005;
        cmp_cfg.off_point[1] = 16'h000A;
        cmp_cfg.off_pulse_length[1] = 16'h0002;
        cmp_cfg.on_point[8] = 16'h0005;
        cmp_cfg.off_point[8] = 16'h000A;
        cmp_cfg.on_point[16] = 16'h0000;
        cmp_cfg.off_point[16] = 16'h0013;
        enc_pins = 4'h0;
        in_pins = 8'h00;
        tick(2);
        chk("bits in reset", status_bit_image, 32'h00000000);
        chk("comp in reset", comp_out, 32'h00000000);
        tick(2);
        sys_rst = 1'b0;
        tick(3);
        chk("ready", status_bit_image[30], 32'h00000001);
        chk("error", status_bit_image[31], 32'h00000000);
        foreach (rows[i]) begin
            cfg.preload_value = rows[i].pv;
            host.cmd(qprc_pkg::CB_PRELOAD);
            chk_cnt(rows[i].pv);
            chk("cmp1", comp_out[0], rows[i].cmp[0]);
            chk("cmp2", comp_out[1], rows[i].cmp[1]);
            chk("cmp9", status_bit_image[8], rows[i].cmp[2]);
            chk("out9", comp_out[8], rows[i].cmp[2]);
            tick(40);
            chk("pulse end", comp_out[1:0], 32'h00000000);
        end
        // Wrap past the limit both ways; comparator 17 turns on at zero
        cfg.preload_value = 16'h0013;
        host.cmd(qprc_pkg::CB_PRELOAD);
        chk("cmp17 off", status_word_image[12][0], 32'h00000000);
        step(1'b1, 2);
        chk_cnt(16'h0000);
        chk("cmp17 on", status_word_image[12][0], 32'h00000001);
        chk("out17", comp_out[16], 32'h00000001);
        step(1'b0, 1);
        chk_cnt(16'h0014);
        // Homing: only the first marker reloads
        in_pins[0] = 1'b1;
        host.cmd(qprc_pkg::CB_HOME);
        pulse_pin(1);
        chk_cnt(16'h000F);
        chk("home found", status_bit_image[24], 32'h00000001);
        chk("home sw", status_bit_image[26], 32'h00000001);
        step(1'b1, 1);
        pulse_pin(1);
        chk_cnt(16'h0010);
        // Panel preload latches and locks out further panel preloads
        cfg.preload_value = 16'h0003;
        pulse_pin(0);
        chk_cnt(16'h0003);
        chk("pl latch", status_bit_image[25], 32'h00000001);
        step(1'b1, 1);
        pulse_pin(0);
        chk_cnt(16'h0004);
        host.cmd(qprc_pkg::CB_PRELOAD);
        chk_cnt(16'h0003);
        host.cmd(qprc_pkg::CB_PRELOAD_RST);
        chk("pl clear", status_bit_image[25], 32'h00000000);
        // Strobe 1 capture, lockout, reset and recapture
        in_pins = 8'h1B;
        tick(10);
        chk("in5-8", status_bit_image[29:26], 32'h0000000B);
        chk("strobes", status_bit_image[23:16], 32'h00000011);
        chk("cap", status_word_image[6], 32'h00000003);
        step(1'b1, 1);
        strobe_edge();
        chk("cap held", status_word_image[6], 32'h00000003);
        host.cmd(qprc_pkg::CB_STROBE_RST);
        chk("st clear", status_bit_image[23:20], 32'h00000000);
        strobe_edge();
        chk("recap", status_word_image[6], 32'h00000004);
        // Limit bounds: 9 is refused, 10 is accepted
        cfg.count_limit = 16'h0009;
        tick(3);
        chk("err set", status_bit_image[31], 32'h00000001);
        chk("err code", status_word_image[0], 32'h00000001);
        cfg.count_limit = 16'h000A;
        host.cmd(qprc_pkg::CB_ERR_CLR);
        tick(3);
        chk("err clr", status_bit_image[31], 32'h00000000);
        // Slow filter: a phase change is not counted within 250 clocks, only after the 2000 clock window
        cfg.filter_fast = 1'b0;
        step(1'b1, 1);
        chk_cnt(16'h0004);
        tick(2000);
        chk_cnt(16'h0005);
        // Counting switched off hides the counter bits and refuses preload
        cfg.quadrature_count_function = 1'b0;
        cfg.preload_value = 16'h0007;
        host.cmd(qprc_pkg::CB_PRELOAD);
        tick(2);
        chk("quad off", status_bit_image[29:24], 32'h00000000);
        chk_cnt(16'h0005);
        sys_rst = 1'b1;
        tick(2);
        chk("reset again", comp_out, 32'h00000000);
        sys_rst = 1'b0;
        tick(3);
        chk("ready again", status_bit_image[30], 32'h00000001);
        chk_cnt(16'h0000);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
